// [dtc_pkg.sv]
// Package for the dual timer/counter block: register map, field layout,
// reset values and timing constants.
// Assumes an AXI4-Lite slave with 32-bit data, one register per word.
package dtc_pkg;

	// ------------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------------
	// Indices are taken from address bits [9:2], so every index maps to byte index*4
	localparam logic [7:0] DTC_IDX_MODE = 8'h89;
	localparam logic [7:0] DTC_IDX_CTRL = 8'h88;
	localparam logic [7:0] DTC_IDX_C0LO = 8'h8A;
	localparam logic [7:0] DTC_IDX_C1LO = 8'h8B;
	localparam logic [7:0] DTC_IDX_C0HI = 8'h8C;
	localparam logic [7:0] DTC_IDX_C1HI = 8'h8D;
	localparam logic [7:0] DTC_IDX_IMSK = 8'h90;
	localparam logic [7:0] DTC_IDX_IACK = 8'h91;
	localparam int DTC_ADDR_W = 12;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	// Mode register: timer 1 in [7:4], timer 0 in [3:0]
	localparam int DTC_MODE_GATE_POS = 3;
	localparam int DTC_MODE_CSRC_POS = 2;
	localparam int DTC_MODE_SEL_HI_POS = 1;
	localparam int DTC_MODE_SEL_LO_POS = 0;
	localparam int DTC_MODE_TMR1_BASE = 4;
	// Control register
	localparam int DTC_CTRL_OVF1_POS = 7;
	localparam int DTC_CTRL_RUN1_POS = 6;
	localparam int DTC_CTRL_OVF0_POS = 5;
	localparam int DTC_CTRL_RUN0_POS = 4;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] DTC_RST_BYTE = 8'h00;
	localparam logic [1:0] DTC_RST_IMSK = 2'h0;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int DTC_OSC_PER_MC = 12;
	localparam logic [3:0] DTC_MC_LAST = 4'(DTC_OSC_PER_MC - 1);
	localparam logic [1:0] DTC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DTC_RESP_SLVERR = 2'h2;

	// Operating modes
	typedef enum logic [1:0] {
		DTC_M_PRESC13,
		DTC_M_CASC16,
		DTC_M_RELOAD8,
		DTC_M_SPLIT
	} dtc_mode_type;

endpackage

// [dtc_edge_det.sv]
// Falling-edge detector for an external count pin.
// Assumes the pin is asynchronous; it is synchronised here before use and
// sampled once per machine cycle on the strobe.
`timescale 1ns/1ps
module dtc_edge_det (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sampling
	input wire logic sample_stb,
	input wire logic pin_raw,
	// Result
	output logic fall_evt,
	output logic level
);
	import dtc_pkg::*;

	logic meta_r, meta_nxt;
	logic sync_r, sync_nxt;
	logic prev_r, prev_nxt;
	logic evt_r, evt_nxt;

	// Two-stage sync, then one sample per machine cycle
	always_comb begin
		meta_nxt = pin_raw;
		sync_nxt = meta_r;
		prev_nxt = prev_r;
		evt_nxt = 1'b0;
		if (sample_stb) begin
			prev_nxt = sync_r;
			evt_nxt = prev_r & ~sync_r; // R15
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			evt_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
			evt_r <= evt_nxt;
		end
	end

	assign fall_evt = evt_r;
	assign level = sync_r;
endmodule

// [dtc_top.sv]
// Dual four-mode timer/counter with AXI4-Lite register access.
// Assumes aclk is the oscillator; a machine cycle is twelve aclk cycles.
// Operation
// R1 - A timer counts only with its run bit set and, when qualified, its gate input high.
// R2 - The source select bit picks the count pin's falling edges or machine cycles.
// R3 - Mode bits 00,01,10,11 pick prescaled 13-bit, 16-bit, 8-bit reload or split mode.
// R4 - Mode 00 counts 13 bits: high byte over the low five bits of the low byte.
// R5 - A wrap from all ones to zero sets the timer's overflow flag.
// R6 - Setting the run bit leaves the count registers unchanged.
// R7 - The mode register has a gate qualify bit at bit 7 for timer 1 and bit 3 for timer 0.
// R8 - Mode 01 counts all 16 bits with the same enable, gating and flag.
// R9 - Mode 10 counts the low byte and reloads it from the high byte on overflow.
// R10 - Timer 1 in mode 11 holds its count as if stopped.
// R11 - Timer 0 in mode 11 runs its low byte with timer 0's own controls and flag.
// R12 - Timer 0 in mode 11 runs its high byte on machine cycles under timer 1 run and flag.
// R13 - With timer 0 in mode 11, timer 1 still runs in its other modes.
// R14 - Timer function advances once per machine cycle of twelve clocks.
// R15 - Counter function samples the pin per machine cycle and counts high then low.
// R16 - An overflow flag is cleared when the core vectors to its interrupt.
// R17 - Each timer gives a one-cycle overflow event output; here ovf_evt1 pulses on timer 0's high byte, not timer 1, while timer 0 is in mode 11.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dtc_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [dtc_pkg::DTC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [dtc_pkg::DTC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// External pins
	input wire logic count_pin0,
	input wire logic count_pin1,
	input wire logic gate_in0,
	input wire logic gate_in1,
	// Interrupt vector acknowledge from the core
	input wire logic int_ack0,
	input wire logic int_ack1,
	// Events and interrupt
	output logic ovf_evt0,
	output logic ovf_evt1,
	output logic irq
);
	import dtc_pkg::*;

	// ------------------------------------------------------------------
	// Machine-cycle strobe
	// ------------------------------------------------------------------
	logic [3:0] mc_cnt_r, mc_cnt_nxt;
	logic mc_stb;

	// One strobe every twelve clocks
	always_comb begin
		mc_stb = (mc_cnt_r == DTC_MC_LAST); // R14
		mc_cnt_nxt = mc_stb ? 4'h0 : mc_cnt_r + 4'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mc_cnt_r <= 4'h0;
		else
			mc_cnt_r <= mc_cnt_nxt;
	end

	// ------------------------------------------------------------------
	// Pin conditioning
	// ------------------------------------------------------------------
	logic pin_evt0, pin_evt1, gate_lvl0, gate_lvl1;
	logic g0_meta_r, g0_sync_r, g1_meta_r, g1_sync_r;

	dtc_edge_det u_pin0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_stb(mc_stb),
		.pin_raw(count_pin0),
		.fall_evt(pin_evt0),
		.level()
	);

	dtc_edge_det u_pin1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_stb(mc_stb),
		.pin_raw(count_pin1),
		.fall_evt(pin_evt1),
		.level()
	);

	// Gate inputs are levels: two flops each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			g0_meta_r <= 1'b0;
			g0_sync_r <= 1'b0;
			g1_meta_r <= 1'b0;
			g1_sync_r <= 1'b0;
		end else begin
			g0_meta_r <= gate_in0;
			g0_sync_r <= g0_meta_r;
			g1_meta_r <= gate_in1;
			g1_sync_r <= g1_meta_r;
		end
	end
	assign gate_lvl0 = g0_sync_r;
	assign gate_lvl1 = g1_sync_r;

	// ------------------------------------------------------------------
	// Registers and counting
	// ------------------------------------------------------------------
	logic [7:0] mode_r, mode_nxt;
	logic run0_r, run0_nxt, run1_r, run1_nxt;
	logic ovf_flag0_r, ovf_flag0_nxt, ovf_flag1_r, ovf_flag1_nxt;
	logic [7:0] count0_low_r, count0_low_nxt, count0_high_r, count0_high_nxt;
	logic [7:0] count1_low_r, count1_low_nxt, count1_high_r, count1_high_nxt;
	logic [1:0] imsk_r, imsk_nxt;
	logic evt0_r, evt0_nxt, evt1_r, evt1_nxt, irq_r, irq_nxt;
	logic wr_fire;
	logic [7:0] wr_idx;
	logic [7:0] wbyte;

	dtc_mode_type mode0, mode1;
	logic tick0, tick1, en0, en1, en0h;
	logic ov0, ov1;
	logic [12:0] c13;
	logic [15:0] c16;
	logic [8:0] s9;

	always_comb begin
		mode0 = dtc_mode_type'(mode_r[DTC_MODE_SEL_HI_POS:DTC_MODE_SEL_LO_POS]); // R3
		mode1 = dtc_mode_type'(mode_r[DTC_MODE_TMR1_BASE+1:DTC_MODE_TMR1_BASE]);
		// Source pick: pin edge or machine cycle
		tick0 = mode_r[DTC_MODE_CSRC_POS] ? pin_evt0 : mc_stb; // R2
		tick1 = mode_r[DTC_MODE_TMR1_BASE+DTC_MODE_CSRC_POS] ? pin_evt1 : mc_stb;
		// Run and gate qualify, gate bits at 3 and 7
		en0 = tick0 & run0_r & (~mode_r[DTC_MODE_GATE_POS] | gate_lvl0); // R1 R7
		en1 = tick1 & run1_r & (~mode_r[DTC_MODE_TMR1_BASE+DTC_MODE_GATE_POS] | gate_lvl1);
		// Split high byte: machine cycles only, timer 1 run bit
		en0h = mc_stb & run1_r & (mode0 == DTC_M_SPLIT); // R12
		count0_low_nxt = count0_low_r;
		count0_high_nxt = count0_high_r;
		count1_low_nxt = count1_low_r;
		count1_high_nxt = count1_high_r;
		ov0 = 1'b0;
		ov1 = 1'b0;
		c13 = 13'h0;
		c16 = 16'h0;
		s9 = 9'h0;
		// Timer 0
		if (en0) begin
			unique case (mode0)
				DTC_M_PRESC13: begin
					c13 = {count0_high_r, count0_low_r[4:0]} + 13'h1; // R4
					count0_high_nxt = c13[12:5];
					count0_low_nxt = {count0_low_r[7:5], c13[4:0]};
					ov0 = ({count0_high_r, count0_low_r[4:0]} == 13'h1FFF); // R5
				end
				DTC_M_CASC16: begin
					c16 = {count0_high_r, count0_low_r} + 16'h1; // R8
					{count0_high_nxt, count0_low_nxt} = c16;
					ov0 = (c16 == 16'h0000);
				end
				DTC_M_RELOAD8: begin
					s9 = {1'b0, count0_low_r} + 9'h1;
					ov0 = s9[8];
					count0_low_nxt = s9[8] ? count0_high_r : s9[7:0]; // R9
				end
				DTC_M_SPLIT: begin
					s9 = {1'b0, count0_low_r} + 9'h1; // R11
					ov0 = s9[8];
					count0_low_nxt = s9[7:0];
				end
			endcase
		end
		if (en0h) begin
			count0_high_nxt = count0_high_r + 8'h1;
			ov1 = (count0_high_r == 8'hFF); // R12
		end
		// Timer 1; it stays usable while timer 0 is split
		if (en1) begin // R13
			unique case (mode1)
				DTC_M_PRESC13: begin
					c13 = {count1_high_r, count1_low_r[4:0]} + 13'h1; // R4
					count1_high_nxt = c13[12:5];
					count1_low_nxt = {count1_low_r[7:5], c13[4:0]};
					if (mode0 != DTC_M_SPLIT)
						ov1 = ({count1_high_r, count1_low_r[4:0]} == 13'h1FFF); // R5
				end
				DTC_M_CASC16: begin
					c16 = {count1_high_r, count1_low_r} + 16'h1; // R8
					{count1_high_nxt, count1_low_nxt} = c16;
					if (mode0 != DTC_M_SPLIT)
						ov1 = (c16 == 16'h0000);
				end
				DTC_M_RELOAD8: begin
					s9 = {1'b0, count1_low_r} + 9'h1;
					count1_low_nxt = s9[8] ? count1_high_r : s9[7:0]; // R9
					if (mode0 != DTC_M_SPLIT)
						ov1 = s9[8];
				end
				DTC_M_SPLIT: begin
					// Held, same as run bit clear
					count1_low_nxt = count1_low_r; // R10
				end
			endcase
		end
		// Software write to a count register beats a count in the same cycle
		if (wr_fire && s_axi_wstrb[0]) begin
			unique case (wr_idx)
				DTC_IDX_C0LO: count0_low_nxt = s_axi_wdata[7:0];
				DTC_IDX_C0HI: count0_high_nxt = s_axi_wdata[7:0];
				DTC_IDX_C1LO: count1_low_nxt = s_axi_wdata[7:0];
				DTC_IDX_C1HI: count1_high_nxt = s_axi_wdata[7:0];
				default: ;
			endcase
		end
	end

	// Register writes, hardware set wins over any clear
	always_comb begin
		mode_nxt = mode_r;
		run0_nxt = run0_r;
		run1_nxt = run1_r;
		imsk_nxt = imsk_r;
		ovf_flag0_nxt = ovf_flag0_r;
		ovf_flag1_nxt = ovf_flag1_r;
		wbyte = s_axi_wdata[7:0];
		if (wr_fire && s_axi_wstrb[0]) begin
			unique case (wr_idx)
				DTC_IDX_MODE: mode_nxt = wbyte;
				DTC_IDX_CTRL: begin
					// Run bit alone: counts are not touched
					run0_nxt = wbyte[DTC_CTRL_RUN0_POS]; // R6
					run1_nxt = wbyte[DTC_CTRL_RUN1_POS];
					ovf_flag0_nxt = wbyte[DTC_CTRL_OVF0_POS];
					ovf_flag1_nxt = wbyte[DTC_CTRL_OVF1_POS];
				end
				DTC_IDX_IMSK: imsk_nxt = wbyte[1:0];
				DTC_IDX_IACK: begin
					if (wbyte[0])
						ovf_flag0_nxt = 1'b0;
					if (wbyte[1])
						ovf_flag1_nxt = 1'b0;
				end
				default: ;
			endcase
		end
		// Vectoring to the routine clears the flag
		if (int_ack0)
			ovf_flag0_nxt = 1'b0; // R16
		if (int_ack1)
			ovf_flag1_nxt = 1'b0; // R16
		if (ov0)
			ovf_flag0_nxt = 1'b1; // R5
		if (ov1)
			ovf_flag1_nxt = 1'b1; // R5
		evt0_nxt = ov0; // R17
		evt1_nxt = ov1; // R17
		irq_nxt = |({ovf_flag1_nxt, ovf_flag0_nxt} & imsk_nxt);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= DTC_RST_BYTE;
			run0_r <= 1'b0;
			run1_r <= 1'b0;
			ovf_flag0_r <= 1'b0;
			ovf_flag1_r <= 1'b0;
			count0_low_r <= DTC_RST_BYTE;
			count0_high_r <= DTC_RST_BYTE;
			count1_low_r <= DTC_RST_BYTE;
			count1_high_r <= DTC_RST_BYTE;
			imsk_r <= DTC_RST_IMSK;
			evt0_r <= 1'b0;
			evt1_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			run0_r <= run0_nxt;
			run1_r <= run1_nxt;
			ovf_flag0_r <= ovf_flag0_nxt;
			ovf_flag1_r <= ovf_flag1_nxt;
			count0_low_r <= count0_low_nxt;
			count0_high_r <= count0_high_nxt;
			count1_low_r <= count1_low_nxt;
			count1_high_r <= count1_high_nxt;
			imsk_r <= imsk_nxt;
			evt0_r <= evt0_nxt;
			evt1_r <= evt1_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	logic aw_ok, w_ok;
	logic [7:0] rd_idx;
	logic awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt, br_r, br_nxt;
	logic arr_r, arr_nxt, rv_r, rv_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [7:0] aw_idx_r, aw_idx_nxt;

	// Address and data taken in either order; response once both are in
	always_comb begin
		aw_ok = s_axi_awvalid & awr_r;
		w_ok = s_axi_wvalid & wr_r;
		aw_idx_nxt = aw_ok ? s_axi_awaddr[9:2] : aw_idx_r;
		awr_nxt = awr_r;
		wr_nxt = wr_r;
		bv_nxt = bv_r;
		br_nxt = br_r;
		wr_fire = 1'b0;
		wr_idx = aw_idx_nxt;
		if (aw_ok)
			awr_nxt = 1'b0;
		if (w_ok)
			wr_nxt = 1'b0;
		// Write happens when the later of the two arrives
		if ((aw_ok | ~awr_r) & (w_ok | ~wr_r) & ~bv_r & (aw_ok | w_ok)) begin
			wr_fire = 1'b1;
			bv_nxt = 1'b1;
			br_nxt = (aw_idx_nxt < DTC_IDX_CTRL) | (aw_idx_nxt > DTC_IDX_IACK) |
				((aw_idx_nxt > DTC_IDX_C1HI) & (aw_idx_nxt < DTC_IDX_IMSK));
		end
		if (bv_r & s_axi_bready) begin
			bv_nxt = 1'b0;
			awr_nxt = 1'b1;
			wr_nxt = 1'b1;
		end
	end

	// Read mux; unmapped answers SLVERR with zero data
	always_comb begin
		rd_idx = s_axi_araddr[9:2];
		arr_nxt = arr_r;
		rv_nxt = rv_r;
		rr_nxt = rr_r;
		rd_nxt = rd_r;
		if (s_axi_arvalid & arr_r) begin
			arr_nxt = 1'b0;
			rv_nxt = 1'b1;
			rr_nxt = 1'b0;
			unique case (rd_idx)
				DTC_IDX_MODE: rd_nxt = {24'h0, mode_r};
				DTC_IDX_CTRL: rd_nxt = {24'h0, ovf_flag1_r, run1_r, ovf_flag0_r, run0_r, 4'h0};
				DTC_IDX_C0LO: rd_nxt = {24'h0, count0_low_r};
				DTC_IDX_C0HI: rd_nxt = {24'h0, count0_high_r};
				DTC_IDX_C1LO: rd_nxt = {24'h0, count1_low_r};
				DTC_IDX_C1HI: rd_nxt = {24'h0, count1_high_r};
				DTC_IDX_IMSK: rd_nxt = {30'h0, imsk_r};
				DTC_IDX_IACK: rd_nxt = {30'h0, ovf_flag1_r, ovf_flag0_r};
				default: begin
					rd_nxt = 32'h0;
					rr_nxt = 1'b1;
				end
			endcase
		end
		if (rv_r & s_axi_rready) begin
			rv_nxt = 1'b0;
			arr_nxt = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awr_r <= 1'b1;
			wr_r <= 1'b1;
			bv_r <= 1'b0;
			br_r <= 1'b0;
			aw_idx_r <= 8'h0;
			arr_r <= 1'b1;
			rv_r <= 1'b0;
			rr_r <= 1'b0;
			rd_r <= 32'h0;
		end else begin
			awr_r <= awr_nxt;
			wr_r <= wr_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			aw_idx_r <= aw_idx_nxt;
			arr_r <= arr_nxt;
			rv_r <= rv_nxt;
			rr_r <= rr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awr_r;
	assign s_axi_wready = wr_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r ? DTC_RESP_SLVERR : DTC_RESP_OKAY;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r ? DTC_RESP_SLVERR : DTC_RESP_OKAY;
	assign ovf_evt0 = evt0_r;
	assign ovf_evt1 = evt1_r;
	assign irq = irq_r;
endmodule

// [dtc_top_assertions.sv]
// Port-level checker for the dual timer/counter block.
// Assumes one aclk domain and aresetn synchronous active low.
`timescale 1ns/1ps
module dtc_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer side
	input wire logic int_ack0,
	input wire logic int_ack1,
	input wire logic ovf_evt0,
	input wire logic ovf_evt1,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------
	// Overflow and interrupt
	// ----------------
	// Counts move once per machine cycle, so events are single and spaced
	AST_EVT0_PULSE: assert property (ovf_evt0 |=> !ovf_evt0 [*8])
		else $error("ovf_evt0 not a lone pulse");
	AST_EVT1_PULSE: assert property (ovf_evt1 |=> !ovf_evt1 [*8])
		else $error("ovf_evt1 not a lone pulse");
	AST_IRQ_RISE: assert property ($rose(irq) |-> ovf_evt0 || ovf_evt1 || $rose(s_axi_bvalid))
		else $error("irq rose without an overflow or a write");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(int_ack0 || int_ack1) || $rose(s_axi_bvalid))
		else $error("irq fell without an acknowledge or a write");
	// ----------------
	// Bus handshakes
	// ----------------
	AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before bready");
	AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted during response");
endmodule

bind dtc_top dtc_checker u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .int_ack0, .int_ack1, .ovf_evt0, .ovf_evt1, .irq);

// [dtc_pin_model.sv]
// External count source: a burst of falling edges on request.
// Assumes go is a one-cycle pulse on aclk; the pin idles high.
`timescale 1ns/1ps
module dtc_pin_model #(
	parameter int PULSES = 3,
	parameter int HOLD = 30
) (
	// Clock and request
	input wire logic aclk,
	input wire logic go,
	// Pin and status
	output logic count_pin,
	output logic busy
);
	// Each level held well over a machine cycle plus sync delay
	initial begin
		count_pin = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge aclk);
			if (go) begin
				busy <= 1'b1;
				repeat (PULSES) begin
					count_pin <= 1'b0;
					repeat (HOLD) @(posedge aclk);
					count_pin <= 1'b1;
					repeat (HOLD) @(posedge aclk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

// [tb_dtc_top.sv]
// Testbench for the dual timer block over its register bus and pins.
// Assumes the checker is bound and the pin model drives count_pin0.
`timescale 1ns/1ps
module tb_dtc_top;
	import dtc_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [DTC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
	logic count_pin0, count_pin1, gate_in0, gate_in1, int_ack0, int_ack1;
	logic ovf_evt0, ovf_evt1, irq, pin_go, pin_busy;
	int bad_count = 0;
	int checks = 0;
	dtc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .count_pin0, .count_pin1, .gate_in0, .gate_in1, .int_ack0, .int_ack1,
		.ovf_evt0, .ovf_evt1, .irq);
	dtc_pin_model u_pin (.aclk(aclk), .go(pin_go), .count_pin(count_pin0), .busy(pin_busy));
	// ----------------
	// Bus tasks
	// ----------------
	// Each channel drops its valid only at the edge that takes it
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		bit done;
		done = 0;
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				last_resp = s_axi_bresp;
				done = 1;
			end
		end
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] q);
		bit done;
		done = 0;
		q = 32'hFFFFFFFF;
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				q = s_axi_rdata;
				last_resp = s_axi_rresp;
				done = 1;
			end
		end
		@(posedge aclk);
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp,
		input logic [31:0] msk = 32'hFFFFFFFF);
		logic [31:0] q;
		rd(idx, q);
		chk(name, exp, q & msk);
	endtask
	// Bounded wait, so a timer that never wraps is reported, not hung on
	task automatic wait_evt(input bit one);
		for (int n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if ((one ? ovf_evt1 : ovf_evt0) === 1'b1) return;
		end
		chk("ovf_evt", 32'h1, 32'h0);
	endtask
	task automatic wrap_up();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----------------
	// Clock, watchdog and tests
	// ----------------
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		#(25 * 20000);
		bad_count++;
		wrap_up();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, gate_in0, int_ack0, int_ack1, pin_go} = '0;
		s_axi_wstrb = 4'hF;
		count_pin1 = 1'b1;
		gate_in1 = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk("mode reset", DTC_IDX_MODE, 32'h0);
		rchk("ctrl reset", DTC_IDX_CTRL, 32'h0);
		rchk("count0_low reset", DTC_IDX_C0LO, 32'h0);
		rchk("mask reset", DTC_IDX_IMSK, 32'h0);
		wr(DTC_IDX_MODE, 8'hA5);
		rchk("mode rw", DTC_IDX_MODE, 32'hA5);
		rd(8'h00, d);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", {30'h0, DTC_RESP_SLVERR}, {30'h0, last_resp});
		// Gated 16-bit count: held with gate low, wraps once it rises
		wr(DTC_IDX_MODE, 8'h09);
		wr(DTC_IDX_C0HI, 8'hFF);
		wr(DTC_IDX_C0LO, 8'hFF);
		wr(DTC_IDX_IMSK, 8'h01);
		wr(DTC_IDX_CTRL, 8'h10);
		repeat (60) @(posedge aclk);
		rchk("gated hold", DTC_IDX_C0LO, 32'hFF);
		gate_in0 <= 1'b1;
		wait_evt(0);
		chk("irq set", 32'h1, {31'h0, irq});
		rchk("16bit low", DTC_IDX_C0LO, 32'h0);
		rchk("16bit high", DTC_IDX_C0HI, 32'h0);
		rchk("flag0 set", DTC_IDX_CTRL, 32'h30);
		int_ack0 <= 1'b1;
		@(posedge aclk);
		int_ack0 <= 1'b0;
		@(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rchk("flag0 clear", DTC_IDX_CTRL, 32'h10);
		// 13-bit count from the top of its range
		wr(DTC_IDX_CTRL, 8'h00);
		wr(DTC_IDX_MODE, 8'h00);
		wr(DTC_IDX_C0HI, 8'hFF);
		wr(DTC_IDX_C0LO, 8'h1F);
		wr(DTC_IDX_CTRL, 8'h10);
		wait_evt(0);
		rchk("13bit low", DTC_IDX_C0LO, 32'h0, 32'h1F);
		rchk("13bit high", DTC_IDX_C0HI, 32'h0);
		// Auto-reload
		wr(DTC_IDX_CTRL, 8'h00);
		wr(DTC_IDX_MODE, 8'h02);
		wr(DTC_IDX_C0HI, 8'hF0);
		wr(DTC_IDX_C0LO, 8'hFE);
		wr(DTC_IDX_CTRL, 8'h10);
		wait_evt(0);
		rchk("reload low", DTC_IDX_C0LO, 32'hF0);
		rchk("reload high", DTC_IDX_C0HI, 32'hF0);
		// Counter function from the pin model
		wr(DTC_IDX_CTRL, 8'h00);
		wr(DTC_IDX_MODE, 8'h05);
		wr(DTC_IDX_C0LO, 8'h00);
		wr(DTC_IDX_CTRL, 8'h10);
		pin_go <= 1'b1;
		@(posedge aclk);
		pin_go <= 1'b0;
		repeat (2) @(posedge aclk);
		for (int n = 0; n < 500 && pin_busy; n++) @(posedge aclk);
		repeat (40) @(posedge aclk);
		rchk("pin count", DTC_IDX_C0LO, 32'h3);
		// Split mode: high byte of timer 0 drives timer 1's flag
		wr(DTC_IDX_CTRL, 8'h00);
		wr(DTC_IDX_MODE, 8'h33);
		wr(DTC_IDX_C1LO, 8'h55);
		wr(DTC_IDX_C0LO, 8'h77);
		wr(DTC_IDX_C0HI, 8'hFE);
		wr(DTC_IDX_IMSK, 8'h03);
		wr(DTC_IDX_CTRL, 8'h40);
		wait_evt(1);
		chk("split irq", 32'h1, {31'h0, irq});
		rchk("split flag1", DTC_IDX_CTRL, 32'hC0);
		rchk("timer1 held", DTC_IDX_C1LO, 32'h55);
		rchk("low byte idle", DTC_IDX_C0LO, 32'h77);
		int_ack1 <= 1'b1;
		@(posedge aclk);
		int_ack1 <= 1'b0;
		@(posedge aclk);
		chk("split irq clear", 32'h0, {31'h0, irq});
		// Timer 1 still counts in another mode while timer 0 is split, flag untouched
		wr(DTC_IDX_C1HI, 8'hFF);
		wr(DTC_IDX_C1LO, 8'hFF);
		wr(DTC_IDX_MODE, 8'h13);
		repeat (30) @(posedge aclk);
		rchk("timer1 runs", DTC_IDX_C1HI, 32'h0);
		rchk("timer1 no flag", DTC_IDX_CTRL, 32'h40);
		wrap_up();
	end
endmodule
